// File: src/qup_pkg.sv
// Constants, field positions and carrier types for the quad UART host pin block.
// Assumes one 25 MHz clock and host pins that are already synchronous to it.
package qup_pkg;
   localparam int NUM_CH = 4;
   localparam int CLK_MHZ = 25;

   // Per-channel register offsets on the three low address lines.
   localparam logic [2:0] OFS_IER = 3'h1;
   localparam logic [2:0] OFS_ISR = 3'h2;
   localparam logic [2:0] OFS_MCR = 3'h4;
   localparam logic [2:0] OFS_EFR = 3'h5;
   localparam logic [2:0] OFS_MSR = 3'h6;

   // Field positions.
   localparam int IER_RX = 0;
   localparam int IER_TX = 1;
   localparam int IER_LINE = 2;
   localparam int IER_MODEM = 3;
   localparam int MCR_RTS_BIT = 1;
   localparam int MCR_INT_EN_BIT = 3;
   localparam int EFR_AUTO_RTS_BIT = 6;
   localparam int MSR_RING_DELTA_BIT = 2;
   localparam int MSR_RING_BIT = 6;

   // Sync vector layout: read strobe, write strobe, then four chip selects.
   localparam int SY_IOR = 0;
   localparam int SY_IOW = 1;
   localparam int SY_CS = 2;
   localparam int SY_W = 6;

   // Reset values.
   localparam logic [3:0] IER_RESET = 4'h0;
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam logic [7:0] EFR_RESET = 8'h00;

   // Interrupt source codes, highest priority first.
   localparam logic [2:0] ISR_LINE = 3'h3;
   localparam logic [2:0] ISR_RX = 3'h2;
   localparam logic [2:0] ISR_TX = 3'h1;
   localparam logic [2:0] ISR_MODEM = 3'h0;

   typedef struct packed {
      logic [3:0] rx_ready;
      logic [3:0] tx_empty;
      logic [3:0] line_error;
      logic [3:0] rx_above_trigger;
   } qup_events_t;

   typedef struct packed {
      logic [3:0] interrupt_enable_register;
      logic [7:0] modem_control_register;
      logic [7:0] enhanced_feature_register;
      logic       ring_prev;
      logic       ring_delta;
   } qup_chan_t;
endpackage

// File: src/qup_host_port.sv
// Host pin logic of a four-channel UART: strobe decode, per-channel control
// registers, interrupt outputs, ring detect and request-to-send pins.
// Assumes all host pins are synchronous to clk and the host holds address
// and data stable around each strobe edge.
// Operation
// - Strobe mode: write strobe falling edge stores data bus into addressed register.
// - Read/write mode: write strobe pin becomes the read/write select input.
// - Read/write mode: all four channel interrupts merge onto one shared request.
// - Read/write mode: shared request driven low when any enabled channel interrupt is pending.
// - Strobe mode: high reset pin returns registers and outputs to reset state.
// - During reset each channel's transmit output and receive input are disabled.
// - Read/write mode: reset pin is active low with the same effect.
// - Ring input rising edge raises a modem status interrupt for that channel.
// - Modem control request-to-send bit set drives request-to-send pin low.
// - After reset every request-to-send pin is high.
// - Request-to-send affects data flow only with automatic flow control enabled.
// - Read/write mode: select high reads, low writes; chip select and five lines.
// - Strobe mode: read strobe falling edge places addressed register on data bus.
// - Strobe mode: channel interrupt pin enabled by modem control bit three.
`timescale 1ns/1ns
`default_nettype none
module qup_host_port (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               strobe_mode,
   input  wire logic               reset_pin,
   input  wire logic               io_write_strobe_n,
   input  wire logic               io_read_strobe_n,
   input  wire logic [3:0]         chip_select_n,
   input  wire logic [4:0]         register_address_lines,
   input  wire logic [7:0]         host_data_bus,
   input  wire logic               interrupt_select,
   input  wire logic [3:0]         line_call_alert_n,
   input  var  qup_pkg::qup_events_t chan_events,
   output logic [7:0]              host_data_out,
   output logic                    host_data_oe,
   output logic [3:0]              channel_interrupt_out,
   output logic [3:0]              channel_interrupt_oe,
   output logic                    shared_irq_n_out,
   output logic                    shared_irq_n_oe,
   output logic [3:0]              request_to_send_n,
   output logic [3:0]              flow_stop,
   output logic [3:0]              tx_enable,
   output logic [3:0]              rx_enable
);
   typedef struct packed {
      logic [qup_pkg::SY_W-1:0] s1;
      logic [qup_pkg::SY_W-1:0] s2;
      logic [qup_pkg::SY_W-1:0] s3;
      qup_pkg::qup_chan_t [3:0] ch;
      logic [7:0]               rdata;
      logic                     rdata_oe;
      logic [3:0]               int_out;
      logic [3:0]               int_oe;
      logic                     irq_oe;
      logic [3:0]               rts_n;
      logic [3:0]               flow_stop;
      logic [3:0]               trx_en;
   } qup_state_t;

   qup_state_t st;
   qup_state_t next_st;
   logic       pin_reset;
   logic       rst_all;
   logic       wr_fire;
   logic       rd_fire;
   logic [1:0] sel_ch;
   logic       sel_any;
   logic [3:0] pending;
   logic [7:0] rd_mux;

   // The reset pin polarity follows the bus mode.
   assign pin_reset = strobe_mode ? reset_pin : !reset_pin;
   assign rst_all = srst | pin_reset;

   // Only the second sync stage and its delayed copy are looked at, so a
   // strobe bounce shorter than a clock cannot make a second access.
   always_comb begin
      logic ior_fall;
      logic iow_fall;
      logic cs_fall;
      ior_fall = 1'b0;
      iow_fall = 1'b0;
      cs_fall = 1'b0;
      sel_ch = 2'h0;
      sel_any = 1'b0;
      ior_fall = st.s3[qup_pkg::SY_IOR] & !st.s2[qup_pkg::SY_IOR];
      iow_fall = st.s3[qup_pkg::SY_IOW] & !st.s2[qup_pkg::SY_IOW];
      cs_fall = st.s3[qup_pkg::SY_CS] & !st.s2[qup_pkg::SY_CS];
      if (strobe_mode) begin
         for (int i = 3; i >= 0; i--) begin
            if (!st.s2[qup_pkg::SY_CS+i]) begin
               sel_ch = 2'(i);
               sel_any = 1'b1;
            end
         end
         wr_fire = iow_fall & sel_any;
         rd_fire = ior_fall & sel_any;
      end else begin
         // The write strobe pin carries read/write select; chip select times it.
         sel_ch = register_address_lines[4:3];
         sel_any = !st.s2[qup_pkg::SY_CS];
         wr_fire = cs_fall & !st.s2[qup_pkg::SY_IOW];
         rd_fire = cs_fall & st.s2[qup_pkg::SY_IOW];
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_pend
      assign pending[g] = |(st.ch[g].interrupt_enable_register & {st.ch[g].ring_delta, chan_events.line_error[g],
                                             chan_events.tx_empty[g],
                                             chan_events.rx_ready[g]});
   end

   always_comb begin
      qup_pkg::qup_chan_t c;
      logic [2:0] id;
      c = st.ch[sel_ch];
      id = qup_pkg::ISR_MODEM;
      if (c.interrupt_enable_register[qup_pkg::IER_TX] & chan_events.tx_empty[sel_ch]) id = qup_pkg::ISR_TX;
      if (c.interrupt_enable_register[qup_pkg::IER_RX] & chan_events.rx_ready[sel_ch]) id = qup_pkg::ISR_RX;
      if (c.interrupt_enable_register[qup_pkg::IER_LINE] & chan_events.line_error[sel_ch]) id = qup_pkg::ISR_LINE;
      unique case (register_address_lines[2:0])
         qup_pkg::OFS_IER: rd_mux = {4'h0, c.interrupt_enable_register};
         qup_pkg::OFS_ISR: rd_mux = {4'h0, id, !pending[sel_ch]};
         qup_pkg::OFS_MCR: rd_mux = c.modem_control_register;
         qup_pkg::OFS_EFR: rd_mux = c.enhanced_feature_register;
         qup_pkg::OFS_MSR: begin
            rd_mux = 8'h00;
            rd_mux[qup_pkg::MSR_RING_BIT] = !line_call_alert_n[sel_ch];
            rd_mux[qup_pkg::MSR_RING_DELTA_BIT] = c.ring_delta;
         end
         default: rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.s1 = {chip_select_n, io_write_strobe_n, io_read_strobe_n};
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < 4; i++) begin
         next_st.ch[i].ring_prev = line_call_alert_n[i];
         // A read of the status clears the flag, but a new edge in that cycle wins.
         if (rd_fire && sel_ch == 2'(i) && register_address_lines[2:0] == qup_pkg::OFS_MSR)
            next_st.ch[i].ring_delta = 1'b0;
         if (!st.ch[i].ring_prev && line_call_alert_n[i])
            next_st.ch[i].ring_delta = 1'b1;
         if (wr_fire && sel_ch == 2'(i)) begin
            unique case (register_address_lines[2:0])
               qup_pkg::OFS_IER: next_st.ch[i].interrupt_enable_register = host_data_bus[3:0];
               qup_pkg::OFS_MCR: next_st.ch[i].modem_control_register = host_data_bus;
               qup_pkg::OFS_EFR: next_st.ch[i].enhanced_feature_register = host_data_bus;
               default: ;
            endcase
         end
         next_st.flow_stop[i] = st.ch[i].enhanced_feature_register[qup_pkg::EFR_AUTO_RTS_BIT]
                                & chan_events.rx_above_trigger[i];
         next_st.rts_n[i] = !(st.ch[i].modem_control_register[qup_pkg::MCR_RTS_BIT] & !next_st.flow_stop[i]);
         next_st.int_out[i] = strobe_mode & pending[i];
         next_st.int_oe[i] = strobe_mode & (st.ch[i].modem_control_register[qup_pkg::MCR_INT_EN_BIT]
                             | interrupt_select);
      end
      next_st.irq_oe = !strobe_mode & (|pending);
      next_st.trx_en = 4'hf;
      if (rd_fire)
         next_st.rdata = rd_mux;
      if (strobe_mode)
         next_st.rdata_oe = sel_any & !st.s2[qup_pkg::SY_IOR];
      else
         next_st.rdata_oe = sel_any & st.s2[qup_pkg::SY_IOW];
      if (rst_all) begin
         next_st = '0;
         next_st.s1 = '1;
         next_st.s2 = '1;
         next_st.s3 = '1;
         for (int i = 0; i < 4; i++) begin
            next_st.ch[i].interrupt_enable_register = qup_pkg::IER_RESET;
            next_st.ch[i].modem_control_register = qup_pkg::MCR_RESET;
            next_st.ch[i].enhanced_feature_register = qup_pkg::EFR_RESET;
            next_st.ch[i].ring_prev = 1'b1;
         end
         next_st.rts_n = 4'hf;
         next_st.trx_en = 4'h0;
      end
   end

   always_ff @(posedge clk) begin
      st <= next_st;
   end

   assign host_data_out = st.rdata;
   assign host_data_oe = st.rdata_oe;
   assign channel_interrupt_out = st.int_out;
   assign channel_interrupt_oe = st.int_oe;
   assign shared_irq_n_out = 1'b0;
   assign shared_irq_n_oe = st.irq_oe;
   assign request_to_send_n = st.rts_n;
   assign flow_stop = st.flow_stop;
   assign tx_enable = st.trx_en;
   assign rx_enable = st.trx_en;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_mcr_write0;
      wr_fire && sel_ch == 2'h0 && register_address_lines[2:0] == qup_pkg::OFS_MCR && !rst_all;
   endsequence

   sequence s_ring_edge0;
      !st.ch[0].ring_prev && line_call_alert_n[0] && !rst_all;
   endsequence

   AST_WRITE_STORES: assert property (s_mcr_write0 |=> st.ch[0].modem_control_register == $past(host_data_bus))
      else $error("MODEM_CONTROL_REGISTER write did not store bus data");
   AST_ONE_ACCESS: assert property (wr_fire |=> !wr_fire ##1 !wr_fire)
      else $error("one strobe edge gave more than one write");
   AST_SHARED_IRQ: assert property (!strobe_mode && |pending && !rst_all |=> shared_irq_n_oe)
      else $error("shared interrupt not driven low");
   AST_NO_SHARED_IN_STROBE: assert property (strobe_mode |=> !shared_irq_n_oe)
      else $error("shared interrupt driven in strobe mode");
   AST_RESET_OUTPUTS: assert property (pin_reset |=> request_to_send_n == 4'hf
                                       && tx_enable == 4'h0 && rx_enable == 4'h0)
      else $error("reset did not quiet the channel pins");
   AST_RW_RESET_LOW: assert property (!strobe_mode && !reset_pin |=> tx_enable == 4'h0)
      else $error("low reset pin ignored in read/write mode");
   AST_RING_FLAG: assert property (s_ring_edge0 |=> st.ch[0].ring_delta)
      else $error("ring edge lost");
   AST_RTS_FOLLOWS: assert property (!rst_all && !st.ch[0].enhanced_feature_register[qup_pkg::EFR_AUTO_RTS_BIT]
                                     |=> request_to_send_n[0] == !$past(st.ch[0].modem_control_register[1]))
      else $error("request-to-send pin does not follow control bit");
   AST_INT_ENABLE: assert property (strobe_mode && !rst_all |=>
                                    channel_interrupt_oe[0] == ($past(st.ch[0].modem_control_register[3])
                                    || $past(interrupt_select)))
      else $error("channel interrupt enable wrong");
   AST_READ_DATA: assert property (rd_fire && !rst_all |=> host_data_out == $past(rd_mux))
      else $error("read data not latched on strobe edge");

   // Steps of the read/write select access and of the status read on channel 0.
   sequence s_rw_ier_write0;
      !strobe_mode && wr_fire && sel_ch == 2'h0
      && register_address_lines[2:0] == qup_pkg::OFS_IER && !rst_all;
   endsequence

   sequence s_msr_read_quiet0;
      rd_fire && sel_ch == 2'h0 && register_address_lines[2:0] == qup_pkg::OFS_MSR
      && !rst_all && !(!st.ch[0].ring_prev && line_call_alert_n[0]);
   endsequence

   sequence s_msr_read_edge0;
      rd_fire && sel_ch == 2'h0 && register_address_lines[2:0] == qup_pkg::OFS_MSR
      && !rst_all && !st.ch[0].ring_prev && line_call_alert_n[0];
   endsequence

   AST_RW_WRITE: assert property (s_rw_ier_write0 |=> st.ch[0].interrupt_enable_register == 4'($past(host_data_bus)))
      else $error("read/write mode write did not store bus data");
   AST_RW_EXCLUSIVE: assert property (!strobe_mode && rd_fire |-> !wr_fire)
      else $error("one select edge gave both a read and a write");
   AST_RD_ONE_ACCESS: assert property (rd_fire |=> !rd_fire ##1 !rd_fire)
      else $error("one strobe edge gave more than one read");
   AST_NEED_SELECT: assert property (strobe_mode && !sel_any |-> !wr_fire && !rd_fire)
      else $error("access without a chip select");
   AST_TRX_RESET: assert property (rst_all |=> tx_enable == 4'h0 && rx_enable == 4'h0)
      else $error("serial pins enabled during reset");
   AST_TRX_RUN: assert property (!rst_all |=> tx_enable == 4'hf && rx_enable == 4'hf)
      else $error("serial pins disabled outside reset");
   AST_FLOW_STOP: assert property (!rst_all && st.ch[0].enhanced_feature_register[qup_pkg::EFR_AUTO_RTS_BIT]
                                   && chan_events.rx_above_trigger[0]
                                   |=> flow_stop[0] && request_to_send_n[0])
      else $error("automatic flow control did not stop the channel");
   AST_NO_FLOW_STOP: assert property (!st.ch[0].enhanced_feature_register[qup_pkg::EFR_AUTO_RTS_BIT] |=> !flow_stop[0])
      else $error("flow stop raised without automatic flow control");
   AST_STROBE_RESET: assert property (strobe_mode && reset_pin |=> request_to_send_n == 4'hf
                                      && !host_data_oe && channel_interrupt_oe == 4'h0)
      else $error("high reset pin did not quiet the outputs");
   AST_RESET_CLEARS: assert property (rst_all |=> st.ch[0].modem_control_register == qup_pkg::MCR_RESET
                                      && st.ch[0].interrupt_enable_register == qup_pkg::IER_RESET)
      else $error("reset did not clear the channel registers");
   AST_RD_OE_STROBE: assert property (strobe_mode && !rst_all && sel_any
                                      && !st.s2[qup_pkg::SY_IOR] |=> host_data_oe)
      else $error("data bus not driven during a strobe read");
   AST_RD_OE_RW: assert property (!strobe_mode && !rst_all && !st.s2[qup_pkg::SY_CS]
                                  && st.s2[qup_pkg::SY_IOW] |=> host_data_oe)
      else $error("data bus not driven during a select read");
   AST_DATA_HOLD: assert property (!rd_fire && !rst_all |=> $stable(host_data_out))
      else $error("read data changed without a read");
   AST_SHARED_QUIET: assert property (!(|pending) |=> !shared_irq_n_oe)
      else $error("shared interrupt driven with nothing pending");
   AST_INT_PINS_RW: assert property (!strobe_mode |=> channel_interrupt_out == 4'h0
                                     && channel_interrupt_oe == 4'h0)
      else $error("channel interrupt pins active in read/write mode");
   // A status read clears the ring flag, but an edge in the same cycle must survive.
   AST_RING_CLEAR: assert property (s_msr_read_quiet0 |=> !st.ch[0].ring_delta)
      else $error("status read did not clear the ring flag");
   AST_RING_WINS: assert property (s_msr_read_edge0 |=> st.ch[0].ring_delta)
      else $error("ring edge lost to a status read");
endmodule // qup_host_port
`default_nettype wire

// File: testbench/qup_host_model.sv
// Host CPU model that runs byte accesses on the parallel host pins.
// Assumes pins change at falling clock edges and strobe_mode is held stable.
`timescale 1ns/1ns
`default_nettype none
module qup_host_model (
   input  wire logic       clk,
   input  wire logic       mode,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_oe,
   output logic            wr_n,
   output logic            rd_n,
   output logic [3:0]      cs_n,
   output logic [4:0]      addr,
   output logic [7:0]      data
);
   initial begin
      wr_n = 1'b1;
      rd_n = 1'b1;
      cs_n = 4'hf;
      addr = 5'h00;
      data = 8'h5a;
   end
   // Read data counts only while the device drives the bus, so a missing
   // enable shows as a mismatch rather than a stale value.
   task automatic acc(input logic wr, input logic [1:0] ch, input logic [2:0] ofs,
                      input logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      addr = {ch, ofs};
      data = wr ? d : ~data;
      if (mode) cs_n = ~(4'h1 << ch);
      else wr_n = !wr;
      @(negedge clk);
      if (!mode) cs_n[0] = 1'b0;
      else if (wr) wr_n = 1'b0;
      else rd_n = 1'b0;
      repeat (4) @(negedge clk);
      q = rd_oe ? rd_data : 8'hxx;
      wr_n = 1'b1;
      rd_n = 1'b1;
      cs_n = 4'hf;
      data = ~data;
      repeat (3) @(negedge clk);
   endtask
endmodule // qup_host_model
`default_nettype wire

// File: testbench/quad_uart_host_pins_tb.sv
// Bench for the host pin block: a table of register round trips, then
// flow control, interrupt, ring and reset cases by hand.
// Assumes the host model and all other inputs change at falling edges.
`timescale 1ns/1ns
`default_nettype none
module quad_uart_host_pins_tb;
   typedef struct packed {
      logic       m;
      logic [1:0] ch;
      logic [2:0] ofs;
      logic [7:0] wd;
      logic [7:0] ex;
   } qup_row_t;
   logic                 clk = 1'b0;
   logic                 srst = 1'b1;
   logic                 mode = 1'b1;
   logic                 rst_pin = 1'b0;
   logic                 isel = 1'b0;
   logic [3:0]           ring_n = 4'hf;
   qup_pkg::qup_events_t ev = '0;
   logic                 wr_n, rd_n, doe, irq_out, irq_oe;
   logic [3:0]           cs_n, ci, cioe, rts_n, fstop, txe, rxe;
   logic [4:0]           addr;
   logic [7:0]           data, dout, q;
   int                   num_errors = 0;
   int                   compares = 0;
   qup_row_t             rows [5] = '{
      '{1'b1, 2'd0, qup_pkg::OFS_MCR, 8'h0a, 8'h0a},
      '{1'b1, 2'd3, qup_pkg::OFS_IER, 8'h05, 8'h05},
      '{1'b0, 2'd2, qup_pkg::OFS_MCR, 8'h02, 8'h02},
      '{1'b0, 2'd1, qup_pkg::OFS_EFR, 8'h40, 8'h40},
      '{1'b1, 2'd1, 3'h7, 8'hff, 8'h00}};

   always #20 clk = ~clk;

   qup_host_model host (.clk(clk), .mode(mode), .rd_data(dout), .rd_oe(doe), .wr_n(wr_n),
      .rd_n(rd_n), .cs_n(cs_n), .addr(addr), .data(data));

   qup_host_port dut (.clk(clk), .srst(srst), .strobe_mode(mode), .reset_pin(rst_pin),
      .io_write_strobe_n(wr_n), .io_read_strobe_n(rd_n), .chip_select_n(cs_n),
      .register_address_lines(addr), .host_data_bus(data), .interrupt_select(isel),
      .line_call_alert_n(ring_n), .chan_events(ev), .host_data_out(dout),
      .host_data_oe(doe), .channel_interrupt_out(ci), .channel_interrupt_oe(cioe),
      .shared_irq_n_out(irq_out), .shared_irq_n_oe(irq_oe), .request_to_send_n(rts_n),
      .flow_stop(fstop), .tx_enable(txe), .rx_enable(rxe));

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // The reset pin flips polarity with the bus mode, so both move together.
   task automatic mset(input logic m);
      @(negedge clk);
      mode = m;
      rst_pin = !m;
      tick(3);
   endtask

   task automatic finish_test;
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      finish_test;
   end

   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      tick(4);
      chk(8'(rts_n), 8'h0f);
      chk({txe, rxe}, 8'hff);
      foreach (rows[i]) begin
         mset(rows[i].m);
         host.acc(1'b1, rows[i].ch, rows[i].ofs, rows[i].wd, q);
         host.acc(1'b0, rows[i].ch, rows[i].ofs, 8'h00, q);
         chk(q, rows[i].ex);
      end
      $display("table test done");
      host.acc(1'b1, 2'd1, qup_pkg::OFS_MCR, 8'h02, q);
      tick(2);
      chk(8'(rts_n), 8'h08);
      ev.rx_above_trigger[1] = 1'b1;
      tick(3);
      chk(8'(rts_n), 8'h0a);
      chk(8'(fstop), 8'h02);
      ev.rx_above_trigger[1] = 1'b0;
      $display("flow test done");
      ev.rx_ready[3] = 1'b1;
      tick(3);
      chk(8'(cioe[3]), 8'h00);
      isel = 1'b1;
      tick(2);
      chk(8'({cioe[3], ci[3]}), 8'h03);
      isel = 1'b0;
      host.acc(1'b1, 2'd3, qup_pkg::OFS_MCR, 8'h08, q);
      chk(8'({cioe[3], ci[3]}), 8'h03);
      mset(1'b0);
      chk(8'({irq_oe, irq_out}), 8'h02);
      for (int c = 0; c < 4; c++) begin
         host.acc(1'b0, 2'(c), qup_pkg::OFS_ISR, 8'h00, q);
         chk(q, (c == 3) ? 8'h04 : 8'h01);
      end
      ev.line_error[3] = 1'b1;
      host.acc(1'b0, 2'd3, qup_pkg::OFS_ISR, 8'h00, q);
      chk(q, 8'h06);
      ev.line_error[3] = 1'b0;
      ev.rx_ready[3] = 1'b0;
      tick(3);
      chk(8'(irq_oe), 8'h00);
      $display("interrupt test done");
      ring_n[1] = 1'b0;
      host.acc(1'b0, 2'd1, qup_pkg::OFS_MSR, 8'h00, q);
      chk(q & 8'h04, 8'h00);
      ring_n[1] = 1'b1;
      tick(3);
      host.acc(1'b0, 2'd1, qup_pkg::OFS_MSR, 8'h00, q);
      chk(q & 8'h04, 8'h04);
      $display("ring test done");
      rst_pin = 1'b0;
      tick(2);
      chk({txe, rxe}, 8'h00);
      mset(1'b1);
      rst_pin = 1'b1;
      tick(2);
      chk(8'(rts_n), 8'h0f);
      chk({txe, cioe}, 8'h00);
      rst_pin = 1'b0;
      tick(3);
      host.acc(1'b0, 2'd0, qup_pkg::OFS_MCR, 8'h00, q);
      chk(q, 8'h00);
      $display("reset test done");
      finish_test;
   end
endmodule // quad_uart_host_pins_tb
`default_nettype wire
